//--- verilog/pfp_regs.svh
// Constants of the page flash programming host: timing, fields, lengths
// Operation
// - Load by WE pulse, CE low, OE high
// - Load whole page; unloaded bytes become indeterminate (the host loads only the bytes that commands give it)
// - Next load within 150 us, else programming
// - A14..A6 page, A5..A0 byte; page held
// - Lock off as shipped; three-byte enable sequence
// - Locked: every page write needs three-byte prefix
`ifndef PFP_REGS_SVH
`define PFP_REGS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define PFP_CLK_KHZ      10000
`define PFP_LOAD_WIN_US  150
`define PFP_LOAD_WIN_CYC ((`PFP_LOAD_WIN_US * `PFP_CLK_KHZ) / 1000)
`define PFP_WIN_MARGIN   8
`define PFP_PWRUP_MS     5
`define PFP_PWRUP_CYC    (`PFP_PWRUP_MS * `PFP_CLK_KHZ)
`define PFP_PROG_MS      10
`define PFP_TMO_FACTOR   2
`define PFP_PROG_TMO_CYC (`PFP_PROG_MS * `PFP_CLK_KHZ * `PFP_TMO_FACTOR)
`define PFP_TIMER_W      18

// ****************************************************************
// Address fields, status bits, bus phases, sequence lengths
// ****************************************************************
`define PFP_ADDR_W       15
`define PFP_PAGE_MSB     14
`define PFP_PAGE_LSB     6
`define PFP_BIT_POLL     7
`define PFP_BIT_TOG      6
`define PFP_PH_FIRST     2'h0
`define PFP_PH_STROBE    2'h1
`define PFP_PH_LAST      2'h3
`define PFP_LOCK_LEN     3'h3
`define PFP_LONG_LEN     3'h6

`endif

//--- verilog/pfp_pkg.sv
// Types of the page flash programming host
package pfp_pkg;

  // ****************************************************************
  // User commands and controller states
  // ****************************************************************
  typedef enum logic [2:0] {
    PFP_OP_READ,
    PFP_OP_LOAD,
    PFP_OP_LOCK,
    PFP_OP_UNLOCK,
    PFP_OP_ERASE
  } pfp_op_e;

  typedef enum logic [2:0] {
    PFP_ST_PWR,
    PFP_ST_IDLE,
    PFP_ST_SEQ,
    PFP_ST_LOAD,
    PFP_ST_OPEN,
    PFP_ST_READ,
    PFP_ST_POLL
  } pfp_state_e;

  // ****************************************************************
  // Whole state of the host controller
  // ****************************************************************
  typedef struct packed {
    pfp_state_e  state;
    pfp_op_e     kind;
    logic [1:0]  ph;
    logic        rd;
    logic [2:0]  idx;
    logic [2:0]  len;
    logic [17:0] timer;
    logic        loadable;
    logic        chk7;
    logic [14:0] addr;
    logic [7:0]  wdata;
    logic [14:0] last_addr;
    logic [7:0]  last_data;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        dq_oe;
    logic [7:0]  dq_s1;
    logic [7:0]  dq_s2;
    logic [7:0]  rdata;
    logic        rd_valid;
    logic        done;
    logic        tmo;
  } pfp_host_s;

  typedef struct packed {
    logic       have;
    logic [7:0] prev;
  } pfp_poll_s;

endpackage : pfp_pkg

//--- verilog/pfp_poll.sv
// Completion detector for status reads during a program or erase cycle
`timescale 1ns/1ps
`include "pfp_regs.svh"

module pfp_poll (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Control
  input  wire logic       clear,
  input  wire logic       chk7,
  input  wire logic       exp7,
  // Samples
  input  wire logic       smp_valid,
  input  wire logic [7:0] smp_byte,
  // Result
  output logic            settled
);

  pfp_pkg::pfp_poll_s p_reg;
  pfp_pkg::pfp_poll_s p_next;

  // Settled when bit 6 holds still and, with chk7 set, bit 7 is true again
  assign settled = smp_valid && p_reg.have &&
                   (p_reg.prev[`PFP_BIT_TOG] == smp_byte[`PFP_BIT_TOG]) &&
                   (!chk7 || (smp_byte[`PFP_BIT_POLL] == exp7));

  // Remember the previous status read
  always_comb begin
    p_next = p_reg;
    if (clear) begin
      p_next.have = 1'b0;
    end else if (smp_valid) begin
      p_next.have = 1'b1;
      p_next.prev = smp_byte;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      p_reg <= '0;
    end else begin
      p_reg <= p_next;
    end
  end

endmodule : pfp_poll

//--- verilog/pfp_host.sv
// Host controller driving a page programmed parallel flash through its pins
`timescale 1ns/1ps
`include "pfp_regs.svh"

module pfp_host #(
  parameter int          PWRUP_CYC    = `PFP_PWRUP_CYC,
  parameter int          PROG_TMO_CYC = `PFP_PROG_TMO_CYC,
  // Code sequence table, entry 0 in the low bits; values are arbitrary
  parameter logic [89:0] SEQ_ADDR     = 90'h0,
  parameter logic [23:0] LOCK_DATA    = 24'h00_0000,
  parameter logic [47:0] UNLOCK_DATA  = 48'h0000_0000_0000,
  parameter logic [47:0] ERASE_DATA   = 48'h0000_0000_0000
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // User command port
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [2:0]  cmd_op,
  input  wire logic [14:0] cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  input  wire logic        software_write_lock_on,
  // User answers
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  output logic             op_done,
  output logic             op_timeout,
  output logic             busy,
  // Flash pins
  output logic [14:0]      byte_address_lines,
  output logic             chip_sel_n,
  output logic             out_gate_n,
  output logic             wr_strobe_n,
  input  wire logic [7:0]  data_lines_i,
  output logic [7:0]       data_lines_o,
  output logic             data_lines_oe
);

  localparam int WIN_CYC    = `PFP_LOAD_WIN_CYC;
  localparam int ACCEPT_CYC = `PFP_LOAD_WIN_CYC - `PFP_WIN_MARGIN;

  // Refuse counts that the timer cannot hold
  if (PWRUP_CYC < 1 || PWRUP_CYC >= (1 << `PFP_TIMER_W) ||
      PROG_TMO_CYC < 1 || PROG_TMO_CYC >= (1 << `PFP_TIMER_W) ||
      ACCEPT_CYC < 1) begin : g_bad_timing
    $error("pfp_host: timing parameter out of range");
  end

  pfp_pkg::pfp_host_s r_reg;
  pfp_pkg::pfp_host_s r_next;
  logic               accept;
  logic               same_page;
  logic               settled;
  logic               bus_end;
  logic               smp_valid;
  logic [22:0]        code;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Address and data of one entry of a code sequence
  function automatic logic [22:0] code_entry(input pfp_pkg::pfp_op_e k,
                                             input logic [2:0] i);
    logic [7:0] d;
    d = 8'h00;
    case (k)
      pfp_pkg::PFP_OP_LOCK:   d = LOCK_DATA[8*i +: 8];
      pfp_pkg::PFP_OP_UNLOCK: d = UNLOCK_DATA[8*i +: 8];
      default:                d = ERASE_DATA[8*i +: 8];
    endcase
    return {SEQ_ADDR[15*i +: 15], d};
  endfunction : code_entry

  // Pin levels for one phase of a bus cycle
  function automatic logic [3:0] bus_pins(input logic act,
                                          input logic rd,
                                          input logic [1:0] ph);
    logic [3:0] p;
    p = 4'h0;
    if (!act || ph == `PFP_PH_LAST) begin
      p = 4'he;
    end else if (rd) begin
      p = {1'b0, (ph == `PFP_PH_FIRST), 1'b1, 1'b0};
    end else begin
      p = {1'b0, 1'b1, (ph != `PFP_PH_STROBE), 1'b1};
    end
    return p;
  endfunction : bus_pins

  // ****************************************************************
  // Command acceptance and completion detection
  // ****************************************************************

  // Loads keep to the open page and the remaining window
  assign same_page = cmd_addr[`PFP_PAGE_MSB:`PFP_PAGE_LSB] ==
                     r_reg.last_addr[`PFP_PAGE_MSB:`PFP_PAGE_LSB];
  assign cmd_ready = (r_reg.state == pfp_pkg::PFP_ST_IDLE) ||
                     (r_reg.state == pfp_pkg::PFP_ST_OPEN && r_reg.loadable &&
                      cmd_op == pfp_pkg::PFP_OP_LOAD && same_page &&
                      r_reg.timer < ACCEPT_CYC[17:0]);
  assign accept    = cmd_valid && cmd_ready;
  assign bus_end   = r_reg.ph == `PFP_PH_LAST;
  assign smp_valid = r_reg.state == pfp_pkg::PFP_ST_POLL && bus_end;
  assign code      = code_entry(r_reg.kind, r_reg.idx);

  pfp_poll u_poll (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .clear     (r_reg.state != pfp_pkg::PFP_ST_POLL),
    .chk7      (r_reg.chk7),
    .exp7      (r_reg.last_data[`PFP_BIT_POLL]),
    .smp_valid (smp_valid),
    .smp_byte  (r_reg.dq_s2),
    .settled   (settled)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Sequencer: power delay, code bytes, page loads, reads, polling
  always_comb begin
    r_next          = r_reg;
    r_next.rd_valid = 1'b0;
    r_next.done     = 1'b0;
    r_next.tmo      = 1'b0;
    r_next.dq_s1    = data_lines_i;
    r_next.dq_s2    = r_reg.dq_s1;
    r_next.ph       = r_reg.ph + 2'h1;
    r_next.timer    = r_reg.timer + 18'h0_0001;
    if (accept) begin
      r_next.ph    = `PFP_PH_FIRST;
      r_next.timer = '0;
      r_next.addr  = cmd_addr;
      r_next.wdata = cmd_wdata;
      r_next.rd    = 1'b0;
      r_next.idx   = 3'h0;
      r_next.kind  = pfp_pkg::pfp_op_e'(cmd_op);
      case (pfp_pkg::pfp_op_e'(cmd_op))
        pfp_pkg::PFP_OP_READ: begin
          r_next.rd    = 1'b1;
          r_next.state = pfp_pkg::PFP_ST_READ;
        end
        pfp_pkg::PFP_OP_LOAD: begin
          r_next.loadable = 1'b1;
          r_next.chk7     = 1'b1;
          if (r_reg.state == pfp_pkg::PFP_ST_IDLE &&
              software_write_lock_on) begin
            // Park the user byte while the code bytes go out
            r_next.last_addr = cmd_addr;
            r_next.last_data = cmd_wdata;
            r_next.kind  = pfp_pkg::PFP_OP_LOCK;
            r_next.len   = `PFP_LOCK_LEN;
            r_next.state = pfp_pkg::PFP_ST_SEQ;
          end else begin
            r_next.state = pfp_pkg::PFP_ST_LOAD;
          end
        end
        pfp_pkg::PFP_OP_LOCK: begin
          r_next.loadable = 1'b1;
          r_next.chk7     = 1'b0;
          r_next.len      = `PFP_LOCK_LEN;
          r_next.state    = pfp_pkg::PFP_ST_SEQ;
        end
        default: begin
          r_next.loadable = 1'b0;
          r_next.chk7     = 1'b0;
          r_next.len      = `PFP_LONG_LEN;
          r_next.state    = pfp_pkg::PFP_ST_SEQ;
        end
      endcase
    end else begin
      case (r_reg.state)
        pfp_pkg::PFP_ST_PWR: begin
          if (r_reg.timer == 18'(PWRUP_CYC - 1)) begin
            r_next.state = pfp_pkg::PFP_ST_IDLE;
          end
        end
        pfp_pkg::PFP_ST_IDLE: begin
          r_next.ph = `PFP_PH_LAST;
        end
        pfp_pkg::PFP_ST_SEQ: begin
          if (bus_end) begin
            r_next.idx = r_reg.idx + 3'h1;
            if (r_reg.idx == r_reg.len - 3'h1) begin
              r_next.timer = '0;
              r_next.state = (r_reg.kind == pfp_pkg::PFP_OP_LOCK &&
                              r_reg.loadable && r_reg.chk7) ?
                             pfp_pkg::PFP_ST_LOAD : pfp_pkg::PFP_ST_OPEN;
              if (r_reg.kind != pfp_pkg::PFP_OP_LOCK) begin
                r_next.last_addr = code[22:8];
              end
              // Prefixed load: the parked user byte follows the code
              if (r_next.state == pfp_pkg::PFP_ST_LOAD) begin
                r_next.addr  = r_reg.last_addr;
                r_next.wdata = r_reg.last_data;
              end
            end
          end
        end
        pfp_pkg::PFP_ST_LOAD: begin
          if (bus_end) begin
            r_next.last_addr = r_reg.addr;
            r_next.last_data = r_reg.wdata;
            r_next.timer     = '0;
            r_next.state     = pfp_pkg::PFP_ST_OPEN;
          end
        end
        pfp_pkg::PFP_ST_OPEN: begin
          r_next.ph = `PFP_PH_LAST;
          if (r_reg.timer == 18'(WIN_CYC)) begin
            r_next.timer = '0;
            r_next.rd    = 1'b1;
            r_next.ph    = `PFP_PH_FIRST;
            r_next.addr  = r_reg.last_addr;
            r_next.state = pfp_pkg::PFP_ST_POLL;
          end
        end
        pfp_pkg::PFP_ST_READ: begin
          if (bus_end) begin
            r_next.rdata    = r_reg.dq_s2;
            r_next.rd_valid = 1'b1;
            r_next.state    = pfp_pkg::PFP_ST_IDLE;
          end
        end
        default: begin
          if (settled) begin
            r_next.done     = 1'b1;
            r_next.loadable = 1'b0;
            r_next.state    = pfp_pkg::PFP_ST_IDLE;
          end else if (r_reg.timer >= 18'(PROG_TMO_CYC - 1)) begin
            r_next.tmo      = 1'b1;
            r_next.loadable = 1'b0;
            r_next.state    = pfp_pkg::PFP_ST_IDLE;
          end
        end
      endcase
    end
    // Code bytes go out from the table, user bytes from the command
    if (r_next.state == pfp_pkg::PFP_ST_SEQ) begin
      {r_next.addr, r_next.wdata} = code_entry(r_next.kind, r_next.idx);
    end
    {r_next.ce_n, r_next.oe_n, r_next.we_n, r_next.dq_oe} =
      bus_pins(r_next.state != pfp_pkg::PFP_ST_PWR &&
               r_next.state != pfp_pkg::PFP_ST_IDLE &&
               r_next.state != pfp_pkg::PFP_ST_OPEN,
               r_next.rd, r_next.ph);
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg       <= '0;
      r_reg.state <= pfp_pkg::PFP_ST_PWR;
      r_reg.ph    <= `PFP_PH_LAST;
      r_reg.ce_n  <= 1'b1;
      r_reg.oe_n  <= 1'b1;
      r_reg.we_n  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign byte_address_lines = r_reg.addr;
  assign data_lines_o       = r_reg.wdata;
  assign data_lines_oe      = r_reg.dq_oe;
  assign chip_sel_n         = r_reg.ce_n;
  assign out_gate_n         = r_reg.oe_n;
  assign wr_strobe_n        = r_reg.we_n;
  assign rd_data            = r_reg.rdata;
  assign rd_valid           = r_reg.rd_valid;
  assign op_done            = r_reg.done;
  assign op_timeout         = r_reg.tmo;
  assign busy               = r_reg.state != pfp_pkg::PFP_ST_IDLE;

endmodule : pfp_host

//--- dv/pfp_flash_model.sv
// Behavioural page flash memory driven by the host under test
`timescale 1ns/1ps
module pfp_flash_model #(
  parameter logic [89:0] SEQ_ADDR    = 90'h0,
  parameter logic [23:0] LOCK_DATA   = 24'h00_0000,
  parameter logic [47:0] UNLOCK_DATA = 48'h0000_0000_0000,
  parameter logic [47:0] ERASE_DATA  = 48'h0000_0000_0000,
  parameter int          WIN_NS      = 150000,
  parameter int          PROG_NS     = 50000,
  parameter int          PWR_NS      = 500
) (
  // Flash pins
  input  wire logic [14:0] byte_address_lines,
  input  wire logic        chip_sel_n,
  input  wire logic        out_gate_n,
  input  wire logic        wr_strobe_n,
  input  wire logic [7:0]  data_lines_in,
  output logic [7:0]       data_lines_out
);
  // ****************************************
  // Array, page latch and status
  // ****************************************
  logic [7:0]  mem [32768];
  logic [14:0] qa [$];
  logic [7:0]  qd [$];
  logic [14:0] acap;
  logic [7:0]  ld;
  logic [7:0]  held = 8'h00;
  logic        lock = 1'b0; // Not cleared by host reset
  logic        busy = 1'b0;
  logic        tog  = 1'b0;
  int          gen  = 0;
  wire         rd_en = !chip_sel_n && !out_gate_n && wr_strobe_n;

  // Array content at power up
  initial
    for (int a = 0; a < 32768; a++)
      mem[a] = 8'(a) ^ 8'h3C;

  function automatic bit hit(input int m, input logic [47:0] d);
    if (qa.size() < m)
      return 1'b0;
    for (int k = 0; k < m; k++)
      if (qa[k] !== SEQ_ADDR[15*k+:15] || qd[k] !== d[8*k+:8])
        return 1'b0;
    return 1'b1;
  endfunction : hit

  // Erase and program the latched page, or run the timer only
  task automatic run();
    int n;
    int k;
    n = qa.size();
    k = 0;
    busy = 1'b1;
    #(PROG_NS);
    if (hit(3, LOCK_DATA)) begin
      lock = 1'b1;
      k = 3;
    end else if (hit(6, UNLOCK_DATA)) begin
      lock = 1'b0;
      k = n;
    end else if (hit(6, ERASE_DATA)) begin
      for (int a = 0; a < 32768; a++)
        mem[a] = 8'hFF;
      k = n;
    end else if (lock) begin
      k = n;
    end
    if (k < n)
      for (int i = 0; i < 64; i++)
        mem[{qa[k][14:6], 6'(i)}] = 8'h5A;
    for (int j = k; j < n; j++)
      mem[{qa[k][14:6], qa[j][5:0]}] = qd[j];
    qa.delete();
    qd.delete();
    busy = 1'b0;
  endtask : run

  // Load window: programming starts when no load follows in time
  task automatic arm(input int g);
    #(WIN_NS);
    if (g == gen)
      run();
  endtask : arm

  // Address taken at the later falling strobe edge
  always @(negedge chip_sel_n or negedge wr_strobe_n)
    if (!chip_sel_n && !wr_strobe_n && out_gate_n)
      acap = byte_address_lines;

  // Data taken at the first rising strobe edge
  always @(posedge chip_sel_n or posedge wr_strobe_n) begin
    if (out_gate_n && (chip_sel_n ^ wr_strobe_n) && !busy
        && $realtime >= PWR_NS) begin
      qa.push_back(acap);
      qd.push_back(data_lines_in);
      ld = data_lines_in;
      gen++;
      fork
        arm(gen);
      join_none
    end
  end

  // Status bit 6 flips on each read while busy
  always @(negedge out_gate_n)
    if (!chip_sel_n && busy)
      tog = ~tog;

  // Released lines show the inverse of the last driven byte
  always @(data_lines_out)
    if (rd_en)
      held = data_lines_out;

  // Read drive; poll status while busy
  assign data_lines_out = !rd_en ? ~held :
    busy ? {~ld[7], tog, ld[5:0]} : mem[byte_address_lines];
endmodule : pfp_flash_model

//--- dv/pfp_host_properties.sv
// Pin protocol checker of the page flash host
`timescale 1ns/1ps
module pfp_host_properties #(
  parameter int PWRUP_CYC = 10
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // User answers
  input wire logic        rd_valid,
  input wire logic        op_done,
  input wire logic        op_timeout,
  input wire logic        busy,
  // Flash pins
  input wire logic [14:0] byte_address_lines,
  input wire logic        chip_sel_n,
  input wire logic        out_gate_n,
  input wire logic        wr_strobe_n,
  input wire logic [7:0]  data_lines_o,
  input wire logic        data_lines_oe
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  logic [10:0] gap_reg;
  logic        pend_reg;
  int          pwr_reg;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // Cycles since strobe low, program pending, power delay count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg  <= 11'h5DC;
      pend_reg <= 1'b0;
      pwr_reg  <= 0;
    end else begin
      if (!wr_strobe_n)
        gap_reg <= 11'h000;
      else if (gap_reg != 11'h5DC)
        gap_reg <= gap_reg + 11'h001;
      if (!wr_strobe_n)
        pend_reg <= 1'b1;
      else if (op_done || op_timeout)
        pend_reg <= 1'b0;
      if (pwr_reg < PWRUP_CYC)
        pwr_reg <= pwr_reg + 1;
    end
  end

  write_frame_a: assert property (
    !wr_strobe_n |-> out_gate_n && !chip_sel_n && data_lines_oe)
    else $error("write strobe outside a write frame");
  ce_first_a: assert property (
    $fell(wr_strobe_n) |-> !$past(chip_sel_n))
    else $error("chip select not low before strobe");
  latch_hold_a: assert property (
    $fell(wr_strobe_n) |=> $rose(wr_strobe_n)
      && $stable(byte_address_lines) && $stable(data_lines_o))
    else $error("address or data moved under strobe");
  read_frame_a: assert property (
    $fell(out_gate_n) |-> !chip_sel_n && wr_strobe_n ##2 out_gate_n)
    else $error("read frame malformed");
  oe_quiet_a: assert property (
    !out_gate_n |-> !data_lines_oe && wr_strobe_n)
    else $error("host drives while flash output on");
  read_walk_a: assert property (
    rd_valid |-> !$past(out_gate_n, 2) && $past(out_gate_n))
    else $error("read answer without read frame");
  poll_late_a: assert property (
    $fell(out_gate_n) |-> gap_reg == 11'h5DC)
    else $error("read inside load window");
  no_load_poll_a: assert property (
    pend_reg && gap_reg == 11'h5DC |-> wr_strobe_n)
    else $error("load during program cycle");
  done_idle_a: assert property (
    op_done |-> ##[0:2] !busy)
    else $error("not idle after completion");
  pwr_wait_a: assert property (
    pwr_reg < PWRUP_CYC |-> busy && chip_sel_n)
    else $error("access in power up delay");

  // Main scenarios
  cover property (op_done);
  cover property (rd_valid);
  cover property ($fell(wr_strobe_n) ##[1:40] $fell(wr_strobe_n));
endmodule : pfp_host_properties

bind pfp_host pfp_host_properties #(.PWRUP_CYC(PWRUP_CYC)) u_chk (
  .mclk, .arst_n, .rd_valid, .op_done, .op_timeout, .busy,
  .byte_address_lines, .chip_sel_n, .out_gate_n, .wr_strobe_n,
  .data_lines_o, .data_lines_oe
);

//--- dv/pfp_host_tb_top.sv
// Self-checking bench of the page flash host against a flash model
`timescale 1ns/1ps
module pfp_host_tb_top;
  // ****************************************
  // Stimulus, model and checks
  // ****************************************
  localparam logic [89:0] SA = {15'h0321, 15'h0654, 15'h0987,
                                15'h2AAA, 15'h5555, 15'h1234};
  localparam logic [23:0] LD = 24'hA0_55AA;
  localparam logic [47:0] UD = 48'h2055_AA80_55AA;
  localparam logic [47:0] ED = 48'h1055_AA80_55AA;
  logic        mclk       = 1'b0;
  logic        arst_n     = 1'b0;
  logic        cmd_valid  = 1'b0;
  logic        lock_on    = 1'b0;
  logic [2:0]  cmd_op     = 3'h0;
  logic [14:0] cmd_addr   = 15'h0000;
  logic [7:0]  cmd_wdata  = 8'h00;
  logic        cmd_ready, rd_valid, op_done, op_timeout, busy;
  logic        ce_n, oe_n, we_n, dq_oe;
  logic [7:0]  rd_data, dq_o, dq_m;
  logic [14:0] adr;
  wire  [7:0]  dq = dq_oe ? dq_o : dq_m;
  int          bad_count  = 0;
  int          n_compared = 0;
  int          cyc        = 0;

  pfp_host #(.PWRUP_CYC(10), .PROG_TMO_CYC(2000), .SEQ_ADDR(SA),
    .LOCK_DATA(LD), .UNLOCK_DATA(UD), .ERASE_DATA(ED)) u_dut (
    .mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .software_write_lock_on(lock_on),
    .rd_data(rd_data), .rd_valid(rd_valid), .op_done(op_done),
    .op_timeout(op_timeout), .busy(busy), .byte_address_lines(adr),
    .chip_sel_n(ce_n), .out_gate_n(oe_n), .wr_strobe_n(we_n),
    .data_lines_i(dq), .data_lines_o(dq_o), .data_lines_oe(dq_oe));

  pfp_flash_model #(.SEQ_ADDR(SA), .LOCK_DATA(LD), .UNLOCK_DATA(UD),
    .ERASE_DATA(ED)) u_flash (
    .byte_address_lines(adr), .chip_sel_n(ce_n), .out_gate_n(oe_n),
    .wr_strobe_n(we_n), .data_lines_in(dq), .data_lines_out(dq_m));

  // Clock and watchdog
  initial
    forever #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      close_out();
    end
  end

  function automatic logic [7:0] init(input logic [14:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction : init

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Hold a command until the edge that takes it
  task automatic issue(input logic [2:0] op, input logic [14:0] a,
                       input logic [7:0] d);
    @(negedge mclk);
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1)
      @(negedge mclk);
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask : issue

  task automatic settle();
    while (op_done !== 1'b1 && op_timeout !== 1'b1)
      @(negedge mclk);
    chk({7'h00, op_done}, 8'h01);
  endtask : settle

  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    issue(pfp_pkg::PFP_OP_READ, a, 8'h00);
    while (rd_valid !== 1'b1)
      @(negedge mclk);
    chk(rd_data, e);
  endtask : rd

  task automatic t_page();
    rd(15'h7FC1, init(15'h7FC1));
    issue(pfp_pkg::PFP_OP_LOAD, 15'h0147, 8'h11);
    issue(pfp_pkg::PFP_OP_LOAD, 15'h0142, 8'hE2);
    issue(pfp_pkg::PFP_OP_LOAD, 15'h017F, 8'h3B);
    settle();
    rd(15'h0147, 8'h11);
    rd(15'h0142, 8'hE2);
    rd(15'h017F, 8'h3B);
    rd(15'h0187, init(15'h0187));
  endtask : t_page

  task automatic t_lock();
    issue(pfp_pkg::PFP_OP_LOCK, 15'h0000, 8'h00);
    settle();
    lock_on = 1'b1;
    issue(pfp_pkg::PFP_OP_LOAD, 15'h0241, 8'hC4);
    settle();
    rd(15'h0241, 8'hC4);
    lock_on = 1'b0;
    @(negedge mclk);
    arst_n = 1'b0;
    @(negedge mclk);
    arst_n = 1'b1;
    issue(pfp_pkg::PFP_OP_LOAD, 15'h0285, 8'h9E);
    settle();
    rd(15'h0285, init(15'h0285));
  endtask : t_lock

  task automatic t_unlock_erase();
    issue(pfp_pkg::PFP_OP_UNLOCK, 15'h0000, 8'h00);
    settle();
    issue(pfp_pkg::PFP_OP_LOAD, 15'h0285, 8'h9E);
    settle();
    rd(15'h0285, 8'h9E);
    issue(pfp_pkg::PFP_OP_ERASE, 15'h0000, 8'h00);
    settle();
    rd(15'h0147, 8'hFF);
    rd(15'h7FC1, 8'hFF);
  endtask : t_unlock_erase

  task automatic close_out();
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    t_page();
    t_lock();
    t_unlock_erase();
    close_out();
  end
endmodule : pfp_host_tb_top
